// file: inc/dmba_pkg.sv
package dmba_pkg;

    localparam int DMBA_DATA_W = 8;
    localparam int DMBA_RAM_AW = 9;

    // special register map, one byte each
    localparam logic [7:0] DMBA_ADDR_IND_ZERO  = 8'h00;
    localparam logic [7:0] DMBA_ADDR_PTR_ZERO  = 8'h01;
    localparam logic [7:0] DMBA_ADDR_IND_ONE   = 8'h02;
    localparam logic [7:0] DMBA_ADDR_PTR_ONE   = 8'h03;
    localparam logic [7:0] DMBA_ADDR_BANK      = 8'h04;
    localparam logic [7:0] DMBA_ADDR_ACC       = 8'h05;
    localparam logic [7:0] DMBA_ADDR_PCL       = 8'h06;
    localparam logic [7:0] DMBA_ADDR_TBL_LOW   = 8'h07;
    localparam logic [7:0] DMBA_ADDR_TBL_HRES  = 8'h08;
    localparam logic [7:0] DMBA_ADDR_TBL_HIGH  = 8'h09;
    localparam logic [7:0] DMBA_ADDR_EEPROM_CT = 8'h40;

    // general purpose ram starts where address bit 7 is set
    localparam int         DMBA_RAM_SEL_BIT    = 7;
    localparam int         DMBA_SFR_AW         = 7;

    // unused special space, read as zero
    localparam logic [7:0] DMBA_UNUSED_A_LO    = 8'h1C;
    localparam logic [7:0] DMBA_UNUSED_A_HI    = 8'h1D;
    localparam logic [7:0] DMBA_UNUSED_B_LO    = 8'h36;
    localparam logic [7:0] DMBA_UNUSED_B_HI    = 8'h3C;
    localparam logic [7:0] DMBA_UNUSED_C_LO    = 8'h41;
    localparam logic [7:0] DMBA_UNUSED_C_HI    = 8'h7F;
    localparam logic [7:0] DMBA_REDUCED_LO     = 8'h20;
    localparam logic [7:0] DMBA_REDUCED_HI     = 8'h24;

    localparam int         DMBA_BANK_SEL_BIT   = 0;
    localparam logic       DMBA_BANK0          = 1'b0;
    localparam logic       DMBA_BANK1          = 1'b1;
    localparam logic [7:0] DMBA_REG_RESET      = 8'h00;
    localparam logic [7:0] DMBA_READ_EMPTY     = 8'h00;

    typedef enum logic [1:0]
    {
        DMBA_ST_IDLE  = 2'b00,
        DMBA_ST_FETCH = 2'b01,
        DMBA_ST_WRITE = 2'b11,
        DMBA_ST_DUMMY = 2'b10
    } dmba_state_t;

    typedef enum logic [1:0]
    {
        DMBA_TGT_NONE  = 2'b00,
        DMBA_TGT_LOCAL = 2'b01,
        DMBA_TGT_SFR   = 2'b10,
        DMBA_TGT_RAM   = 2'b11
    } dmba_tgt_t;

    function automatic logic dmba_is_ind_port(input logic [7:0] a);
        dmba_is_ind_port = (a == DMBA_ADDR_IND_ZERO) || (a == DMBA_ADDR_IND_ONE);
    endfunction

    function automatic logic dmba_sfr_unused(input logic [7:0] a, input logic bank, input logic reduced);
        dmba_sfr_unused = ((a >= DMBA_UNUSED_A_LO) && (a <= DMBA_UNUSED_A_HI))
                       || ((a >= DMBA_UNUSED_B_LO) && (a <= DMBA_UNUSED_B_HI))
                       || ((a >= DMBA_UNUSED_C_LO) && (a <= DMBA_UNUSED_C_HI))
                       || ((a == DMBA_ADDR_EEPROM_CT) && (bank == DMBA_BANK0))
                       || (reduced && (a >= DMBA_REDUCED_LO) && (a <= DMBA_REDUCED_HI));
    endfunction

endpackage

// file: logic/dmba_addr_resolve.sv
`timescale 1ns/100ps
module dmba_addr_resolve
    import dmba_pkg::*;
#(
    parameter logic REDUCED = 1'b0
)
(
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] ptr_zero_i,
    input  wire logic [7:0] ptr_one_i,
    input  wire logic       bank_i,
    output dmba_tgt_t       tgt_o,
    output logic      [7:0] eff_addr_o,
    output logic            eff_bank_o
);

    logic indirect;
    logic sfr_bank;

    always_comb
    begin
        indirect   = 1'b0;
        sfr_bank   = bank_i;
        eff_addr_o = addr_i;
        eff_bank_o = DMBA_BANK0;
        if (addr_i == DMBA_ADDR_IND_ZERO)
        begin
            indirect   = 1'b1;
            eff_addr_o = ptr_zero_i;
            eff_bank_o = DMBA_BANK0;
            sfr_bank   = DMBA_BANK0;
        end
        else if (addr_i == DMBA_ADDR_IND_ONE)
        begin
            indirect   = 1'b1;
            eff_addr_o = ptr_one_i;
            eff_bank_o = bank_i;
        end
        if (indirect && dmba_is_ind_port(eff_addr_o))
            tgt_o = DMBA_TGT_NONE;
        else if (eff_addr_o[DMBA_RAM_SEL_BIT])
            tgt_o = DMBA_TGT_RAM;
        else
        begin
            // special space ignores the bank except for the eeprom control slot
            eff_bank_o = sfr_bank;
            if (dmba_sfr_unused(eff_addr_o, sfr_bank, REDUCED))
                tgt_o = DMBA_TGT_NONE;
            else if (eff_addr_o <= DMBA_ADDR_TBL_HIGH)
                tgt_o = DMBA_TGT_LOCAL;
            else
                tgt_o = DMBA_TGT_SFR;
        end
    end

endmodule

// file: logic/dmba_top.sv
`timescale 1ns/100ps
// Overview of operation
// - indirect port accesses the location its pointer names
// - pair zero bank 0 only, pair one any bank
// - indirect access to a port: read zero, write nothing
// - both pointers are eight bits wide
// - pointers are ordinary readable writable storage
// - direct ram access always lands in bank 0
// - bank select bit 0 picks bank 0 or 1
// - reset clears bank except watchdog power-down reset
// - special registers decode independent of bank, except the eeprom control slot
// - unused special locations read as zero
// - reduced variant: 20H to 24H unused
// - pc low write jumps within current page
// - pc low jump inserts one dummy cycle
// - table read: high byte kept, low byte written
// - alu results land in the accumulator
// - register transfers pass through the accumulator only
// - eeprom control slot reachable only in bank 1
// - bank select bits 7 to 1 read zero
module dmba_top
    import dmba_pkg::*;
#(
    parameter logic REDUCED = 1'b0,
    parameter int   PROG_AW = 16,
    parameter int   PROG_W  = 16
)
(
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   wdt_pd_reset_i,

    input  wire logic                   core_req_i,
    input  wire logic                   core_we_i,
    input  wire logic [7:0]             core_addr_i,
    input  wire logic [DMBA_DATA_W-1:0] core_wdata_i,
    output logic                        core_ready_o,
    output logic      [DMBA_DATA_W-1:0] core_rdata_o,
    output logic                        core_rvalid_o,

    input  wire logic                   alu_we_i,
    input  wire logic [DMBA_DATA_W-1:0] alu_result_i,
    output logic      [DMBA_DATA_W-1:0] acc_o,

    input  wire logic [DMBA_DATA_W-1:0] pc_low_i,
    output logic                        pc_jump_o,
    output logic      [DMBA_DATA_W-1:0] pc_jump_low_o,
    output logic                        pc_dummy_o,

    input  wire logic                   tbl_rd_i,
    input  wire logic [7:0]             tbl_dest_i,
    output logic                        prog_rd_o,
    output logic      [PROG_AW-1:0]     prog_addr_o,
    input  wire logic [PROG_W-1:0]      prog_word_i,
    input  wire logic                   prog_valid_i,

    output logic                        ram_en_o,
    output logic                        ram_we_o,
    output logic      [DMBA_RAM_AW-1:0] ram_addr_o,
    output logic      [DMBA_DATA_W-1:0] ram_wdata_o,
    input  wire logic [DMBA_DATA_W-1:0] ram_rdata_i,

    output logic                        sfr_en_o,
    output logic                        sfr_we_o,
    output logic      [DMBA_SFR_AW-1:0] sfr_addr_o,
    output logic                        sfr_bank_o,
    output logic      [DMBA_DATA_W-1:0] sfr_wdata_o,
    input  wire logic [DMBA_DATA_W-1:0] sfr_rdata_i
);

    localparam int PTR_W = 8;

    generate
        if ((PROG_W <= DMBA_DATA_W) || (PROG_W > 2 * DMBA_DATA_W))
            $error("dmba_top: PROG_W must lie in 9..16");
        if ((PROG_AW <= DMBA_DATA_W) || (PROG_AW > 2 * PTR_W))
            $error("dmba_top: PROG_AW must lie in 9..16");
    endgenerate

    dmba_state_t            state;
    dmba_state_t            next_state;

    logic [PTR_W-1:0]       pointer_zero;
    logic [PTR_W-1:0]       pointer_one;
    logic                   bank_select_bit;
    logic [DMBA_DATA_W-1:0] alu_result_holder;
    logic [DMBA_DATA_W-1:0] table_ptr_low;
    logic [DMBA_DATA_W-1:0] table_ptr_high;
    logic [DMBA_DATA_W-1:0] table_high_result;

    logic [7:0]             tbl_dest;
    logic [DMBA_DATA_W-1:0] tbl_low_byte;

    logic                   acc_act;
    logic                   acc_we;
    logic [7:0]             acc_addr;
    logic [DMBA_DATA_W-1:0] acc_wdata;
    logic                   tbl_take;

    dmba_tgt_t              tgt;
    logic [7:0]             eff_addr;
    logic                   eff_bank;

    logic                   local_wr;
    logic                   pcl_wr;
    logic [DMBA_DATA_W-1:0] local_rdata;
    logic [DMBA_DATA_W-1:0] next_rdata;

    // one access path serves the core and the low byte of a table read, so both
    // obey the same indirect, bank and unused-slot decoding
    always_comb
    begin
        acc_act   = 1'b0;
        acc_we    = 1'b0;
        acc_addr  = core_addr_i;
        acc_wdata = core_wdata_i;
        if (state == DMBA_ST_IDLE)
        begin
            acc_act = core_req_i;
            acc_we  = core_we_i;
        end
        else if (state == DMBA_ST_WRITE)
        begin
            acc_act   = 1'b1;
            acc_we    = 1'b1;
            acc_addr  = tbl_dest;
            acc_wdata = tbl_low_byte;
        end
    end

    assign core_ready_o = (state == DMBA_ST_IDLE);
    assign tbl_take     = (state == DMBA_ST_IDLE) && tbl_rd_i && !core_req_i;

    dmba_addr_resolve
    #(
        .REDUCED    (REDUCED)
    )
    u_dmba_addr_resolve
    (
        .addr_i     (acc_addr),
        .ptr_zero_i (pointer_zero),
        .ptr_one_i  (pointer_one),
        .bank_i     (bank_select_bit),
        .tgt_o      (tgt),
        .eff_addr_o (eff_addr),
        .eff_bank_o (eff_bank)
    );

    assign local_wr = acc_act && acc_we && (tgt == DMBA_TGT_LOCAL);
    assign pcl_wr   = local_wr && (eff_addr == DMBA_ADDR_PCL);

    assign ram_en_o    = acc_act && (tgt == DMBA_TGT_RAM);
    assign ram_we_o    = ram_en_o && acc_we;
    assign ram_addr_o  = {eff_bank, eff_addr};
    assign ram_wdata_o = acc_wdata;

    assign sfr_en_o    = acc_act && (tgt == DMBA_TGT_SFR);
    assign sfr_we_o    = sfr_en_o && acc_we;
    assign sfr_addr_o  = eff_addr[DMBA_SFR_AW-1:0];
    assign sfr_bank_o  = eff_bank;
    assign sfr_wdata_o = acc_wdata;

    // sequencing of table reads and pc low jumps
    always_comb
    begin
        next_state = state;
        case (state)
            DMBA_ST_IDLE:
            begin
                if (pcl_wr)
                    next_state = DMBA_ST_DUMMY;
                else if (tbl_take)
                    next_state = DMBA_ST_FETCH;
            end
            DMBA_ST_FETCH:
            begin
                if (prog_valid_i)
                    next_state = DMBA_ST_WRITE;
            end
            DMBA_ST_WRITE:
            begin
                if (pcl_wr)
                    next_state = DMBA_ST_DUMMY;
                else
                    next_state = DMBA_ST_IDLE;
            end
            DMBA_ST_DUMMY:
                next_state = DMBA_ST_IDLE;
            default:
                next_state = DMBA_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            state <= DMBA_ST_IDLE;
        else
            state <= next_state;
    end

    // pointers are plain storage; increments arrive as read then write
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            pointer_zero <= DMBA_REG_RESET;
        else if (local_wr && (eff_addr == DMBA_ADDR_PTR_ZERO))
            pointer_zero <= acc_wdata;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            pointer_one <= DMBA_REG_RESET;
        else if (local_wr && (eff_addr == DMBA_ADDR_PTR_ONE))
            pointer_one <= acc_wdata;
    end

    // a watchdog reset out of power-down keeps the bank so wake-up code resumes
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            if (!wdt_pd_reset_i)
                bank_select_bit <= DMBA_BANK0;
        end
        else if (local_wr && (eff_addr == DMBA_ADDR_BANK))
            bank_select_bit <= acc_wdata[DMBA_BANK_SEL_BIT];
    end

    // bus write beats the alu in the same cycle; the core issues only one
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            alu_result_holder <= DMBA_REG_RESET;
        else if (local_wr && (eff_addr == DMBA_ADDR_ACC))
            alu_result_holder <= acc_wdata;
        else if (alu_we_i)
            alu_result_holder <= alu_result_i;
    end

    // no memory-to-memory path exists: data moves through the accumulator
    assign acc_o = alu_result_holder;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            table_ptr_low <= DMBA_REG_RESET;
        else if (local_wr && (eff_addr == DMBA_ADDR_TBL_LOW))
            table_ptr_low <= acc_wdata;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            table_ptr_high <= DMBA_REG_RESET;
        else if (local_wr && (eff_addr == DMBA_ADDR_TBL_HIGH))
            table_ptr_high <= acc_wdata;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            table_high_result <= DMBA_REG_RESET;
        else if ((state == DMBA_ST_FETCH) && prog_valid_i)
            table_high_result <= DMBA_DATA_W'(prog_word_i[PROG_W-1:DMBA_DATA_W]);
        else if (local_wr && (eff_addr == DMBA_ADDR_TBL_HRES))
            table_high_result <= acc_wdata;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            tbl_dest     <= DMBA_REG_RESET;
            tbl_low_byte <= DMBA_REG_RESET;
        end
        else
        begin
            if (tbl_take)
                tbl_dest <= tbl_dest_i;
            if ((state == DMBA_ST_FETCH) && prog_valid_i)
                tbl_low_byte <= prog_word_i[DMBA_DATA_W-1:0];
        end
    end

    // pointers are read as loaded by software beforehand
    assign prog_rd_o   = (state == DMBA_ST_FETCH);
    assign prog_addr_o = PROG_AW'({table_ptr_high, table_ptr_low});

    always_comb
    begin
        case (eff_addr)
            DMBA_ADDR_PTR_ZERO:  local_rdata = pointer_zero;
            DMBA_ADDR_PTR_ONE:   local_rdata = pointer_one;
            DMBA_ADDR_BANK:      local_rdata = {7'h00, bank_select_bit};
            DMBA_ADDR_ACC:       local_rdata = alu_result_holder;
            DMBA_ADDR_PCL:       local_rdata = pc_low_i;
            DMBA_ADDR_TBL_LOW:   local_rdata = table_ptr_low;
            DMBA_ADDR_TBL_HRES:  local_rdata = table_high_result;
            DMBA_ADDR_TBL_HIGH:  local_rdata = table_ptr_high;
            default:             local_rdata = DMBA_READ_EMPTY;
        endcase
    end

    always_comb
    begin
        case (tgt)
            DMBA_TGT_LOCAL: next_rdata = local_rdata;
            DMBA_TGT_SFR:   next_rdata = sfr_rdata_i;
            DMBA_TGT_RAM:   next_rdata = ram_rdata_i;
            default:        next_rdata = DMBA_READ_EMPTY;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            core_rdata_o  <= DMBA_READ_EMPTY;
            core_rvalid_o <= 1'b0;
        end
        else
        begin
            core_rvalid_o <= acc_act && !acc_we && (state == DMBA_ST_IDLE);
            if (acc_act && !acc_we)
                core_rdata_o <= next_rdata;
        end
    end

    // only the low byte leaves; the core keeps its upper counter bits
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            pc_jump_o     <= 1'b0;
            pc_jump_low_o <= DMBA_REG_RESET;
        end
        else
        begin
            pc_jump_o <= pcl_wr;
            if (pcl_wr)
                pc_jump_low_o <= acc_wdata;
        end
    end

    assign pc_dummy_o = (state == DMBA_ST_DUMMY);

endmodule

// file: tb/dmba_checker_props.sv
`timescale 1ns/100ps
module dmba_checker
    import dmba_pkg::*;
(
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   core_req_i,
    input  wire logic                   core_we_i,
    input  wire logic [7:0]             core_addr_i,
    input  wire logic [DMBA_DATA_W-1:0] core_wdata_i,
    input  wire logic                   core_ready_o,
    input  wire logic [DMBA_DATA_W-1:0] core_rdata_o,
    input  wire logic                   core_rvalid_o,
    input  wire logic                   alu_we_i,
    input  wire logic [DMBA_DATA_W-1:0] alu_result_i,
    input  wire logic [DMBA_DATA_W-1:0] acc_o,
    input  wire logic                   pc_jump_o,
    input  wire logic [DMBA_DATA_W-1:0] pc_jump_low_o,
    input  wire logic                   pc_dummy_o,
    input  wire logic                   tbl_rd_i,
    input  wire logic                   prog_rd_o,
    input  wire logic                   prog_valid_i,
    input  wire logic                   ram_en_o,
    input  wire logic [DMBA_RAM_AW-1:0] ram_addr_o,
    input  wire logic                   sfr_en_o,
    input  wire logic [DMBA_SFR_AW-1:0] sfr_addr_o,
    input  wire logic                   sfr_bank_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    wire logic take = core_req_i && core_ready_o;

    sequence tbl_take;
        tbl_rd_i && core_ready_o && !core_req_i;
    endsequence
    sequence fetch_done;
        prog_rd_o && prog_valid_i;
    endsequence

    a_read_answer: assert property (take && !core_we_i |=> core_rvalid_o)
        else $error("read not answered in next cycle");
    a_rvalid_cause: assert property (core_rvalid_o |-> $past(take) && !$past(core_we_i))
        else $error("read data valid without a read");
    a_pcl_jump: assert property (take && core_we_i && core_addr_i == DMBA_ADDR_PCL
        |=> pc_jump_o && pc_dummy_o && !core_ready_o && pc_jump_low_o == $past(core_wdata_i))
        else $error("pc low write did not jump");
    a_dummy_single: assert property (pc_dummy_o |=> !pc_dummy_o && core_ready_o)
        else $error("dummy cycle longer than one");
    a_direct_bank0: assert property (take && ram_en_o && core_addr_i[7] |-> ram_addr_o == {1'h0, core_addr_i})
        else $error("direct ram access left bank 0");
    a_ptr0_bank0: assert property (take && ram_en_o && core_addr_i == DMBA_ADDR_IND_ZERO |-> !ram_addr_o[8])
        else $error("pointer zero reached bank 1");
    a_sfr_direct: assert property (take && sfr_en_o && !core_addr_i[7] && core_addr_i > DMBA_ADDR_IND_ONE
        |-> sfr_addr_o == core_addr_i[6:0])
        else $error("special register address altered");
    a_fetch_start: assert property (tbl_take |=> prog_rd_o && !core_ready_o)
        else $error("table read did not fetch");
    a_write_step: assert property (fetch_done |=> !core_ready_o ##1 (core_ready_o || pc_dummy_o))
        else $error("table low byte write step wrong");
    a_acc_load: assert property (alu_we_i && core_ready_o && !(core_req_i && core_we_i)
        |=> acc_o == $past(alu_result_i))
        else $error("accumulator did not take alu result");
    a_bank_upper_zero: assert property (core_rvalid_o && $past(core_addr_i) == DMBA_ADDR_BANK
        |-> core_rdata_o[7:1] == 7'h00)
        else $error("bank register upper bits not zero");
    a_unused_zero: assert property (core_rvalid_o && $past(core_addr_i) == DMBA_UNUSED_A_LO
        |-> core_rdata_o == DMBA_READ_EMPTY)
        else $error("unused location read not zero");
    a_eeprom_bank1: assert property (sfr_en_o && {1'b0, sfr_addr_o} == DMBA_ADDR_EEPROM_CT |-> sfr_bank_o)
        else $error("eeprom control slot reached outside bank 1");
endmodule

bind dmba_top dmba_checker u_dmba_checker (.clock_i, .rst_n_i, .core_req_i, .core_we_i, .core_addr_i,
    .core_wdata_i, .core_ready_o, .core_rdata_o, .core_rvalid_o, .alu_we_i, .alu_result_i, .acc_o, .pc_jump_o,
    .pc_jump_low_o, .pc_dummy_o, .tbl_rd_i, .prog_rd_o, .prog_valid_i, .ram_en_o, .ram_addr_o, .sfr_en_o,
    .sfr_addr_o, .sfr_bank_o);

// file: tb/dmba_mem_model.sv
`timescale 1ns/100ps
module dmba_mem_model
#(
    parameter int WAIT = 2
)
(
    input  wire logic        clock_i,
    input  wire logic        ram_en_i,
    input  wire logic        ram_we_i,
    input  wire logic [8:0]  ram_addr_i,
    input  wire logic [7:0]  ram_wdata_i,
    output logic      [7:0]  ram_rdata_o,
    input  wire logic        sfr_en_i,
    input  wire logic        sfr_we_i,
    input  wire logic [6:0]  sfr_addr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    input  wire logic        prog_rd_i,
    input  wire logic [15:0] prog_addr_i,
    output logic      [15:0] prog_word_o,
    output logic             prog_valid_o
);
    logic [7:0]  ram [512];
    logic [7:0]  sfr [128];
    int          wait_cnt = 0;
    logic [15:0] word;

    // program word is a fixed scramble of its address so the bench can predict it
    assign word         = prog_addr_i ^ 16'hA55A;
    // unselected buses show a pattern, never the last value
    assign ram_rdata_o  = ram_en_i ? ram[ram_addr_i] : 8'h5A;
    assign sfr_rdata_o  = sfr_en_i ? sfr[sfr_addr_i] : 8'hA5;
    assign prog_valid_o = prog_rd_i && (wait_cnt == WAIT);
    assign prog_word_o  = prog_valid_o ? word : ~word;

    always @(posedge clock_i)
    begin
        if (ram_en_i && ram_we_i)
            ram[ram_addr_i] <= ram_wdata_i;
        if (sfr_en_i && sfr_we_i)
            sfr[sfr_addr_i] <= sfr_wdata_i;
        wait_cnt <= (prog_rd_i && !prog_valid_o) ? wait_cnt + 1 : 0;
    end
endmodule

// file: tb/dmba_top_test.sv
`timescale 1ns/100ps
module dmba_top_test
    import dmba_pkg::*;
;
    logic        clock_i        = 1'b0;
    logic        rst_n_i        = 1'b0;
    logic        wdt_pd_reset_i = 1'b0;
    logic        core_req_i     = 1'b0;
    logic        core_we_i      = 1'b0;
    logic [7:0]  core_addr_i    = 8'h00;
    logic [7:0]  core_wdata_i   = 8'h00;
    logic        alu_we_i       = 1'b0;
    logic [7:0]  alu_result_i   = 8'h00;
    logic [7:0]  pc_low_i       = 8'h9A;
    logic        tbl_rd_i       = 1'b0;
    logic [7:0]  tbl_dest_i     = 8'h00;
    wire logic        core_ready_o, core_rvalid_o, pc_jump_o, pc_dummy_o, prog_rd_o, prog_valid_i;
    wire logic        ram_en_o, ram_we_o, sfr_en_o, sfr_we_o, sfr_bank_o;
    wire logic [7:0]  core_rdata_o, acc_o, pc_jump_low_o, ram_wdata_o, ram_rdata_i, sfr_wdata_o, sfr_rdata_i;
    wire logic [15:0] prog_addr_o, prog_word_i;
    wire logic [8:0]  ram_addr_o;
    wire logic [6:0]  sfr_addr_o;
    int          n_mismatch     = 0;
    int          total_checks   = 0;
    logic [7:0]  regs [7]       = '{DMBA_ADDR_PTR_ZERO, DMBA_ADDR_PTR_ONE, DMBA_ADDR_BANK, DMBA_ADDR_ACC,
                                    DMBA_ADDR_TBL_LOW, DMBA_ADDR_TBL_HRES, DMBA_ADDR_TBL_HIGH};

    dmba_top #(.REDUCED(1'b1)) u_dmba_top (.clock_i, .rst_n_i, .wdt_pd_reset_i, .core_req_i, .core_we_i,
        .core_addr_i, .core_wdata_i, .core_ready_o, .core_rdata_o, .core_rvalid_o, .alu_we_i, .alu_result_i,
        .acc_o, .pc_low_i, .pc_jump_o, .pc_jump_low_o, .pc_dummy_o, .tbl_rd_i, .tbl_dest_i, .prog_rd_o,
        .prog_addr_o, .prog_word_i, .prog_valid_i, .ram_en_o, .ram_we_o, .ram_addr_o, .ram_wdata_o,
        .ram_rdata_i, .sfr_en_o, .sfr_we_o, .sfr_addr_o, .sfr_bank_o, .sfr_wdata_o, .sfr_rdata_i);

    dmba_mem_model #(.WAIT(2)) u_dmba_mem_model (.clock_i, .ram_en_i(ram_en_o), .ram_we_i(ram_we_o),
        .ram_addr_i(ram_addr_o), .ram_wdata_i(ram_wdata_o), .ram_rdata_o(ram_rdata_i), .sfr_en_i(sfr_en_o),
        .sfr_we_i(sfr_we_o), .sfr_addr_i(sfr_addr_o), .sfr_wdata_i(sfr_wdata_o), .sfr_rdata_o(sfr_rdata_i),
        .prog_rd_i(prog_rd_o), .prog_addr_i(prog_addr_o), .prog_word_o(prog_word_i), .prog_valid_o(prog_valid_i));

    initial
        forever #5 clock_i = ~clock_i;

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        while (core_ready_o !== 1'b1 && n < 20)
        begin
            @(negedge clock_i);
            n++;
        end
        // a stuck handshake must not slip through as a silent pass
        chk("ready_wait", 8'h01, {7'h00, core_ready_o});
    endtask

    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_i);
        wait_ready();
        core_req_i   = 1'b1;
        core_we_i    = we;
        core_addr_i  = a;
        core_wdata_i = d;
        @(negedge clock_i);
        core_req_i   = 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk("rvalid", 8'h01, {7'h00, core_rvalid_o});
        chk("rdata", exp, core_rdata_o);
    endtask

    task automatic tbl(input logic [7:0] dest);
        @(negedge clock_i);
        tbl_rd_i   = 1'b1;
        tbl_dest_i = dest;
        @(negedge clock_i);
        tbl_rd_i   = 1'b0;
        wait_ready();
    endtask

    task automatic do_reset(input logic wdt);
        @(negedge clock_i);
        wdt_pd_reset_i = wdt;
        rst_n_i        = 1'b0;
        repeat (5) @(negedge clock_i);
        rst_n_i        = 1'b1;
        wdt_pd_reset_i = 1'b0;
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    initial
    begin
        #100000;
        n_mismatch++;
        close_out();
    end

    initial
    begin
        do_reset(1'b0);
        foreach (regs[i]) rd(regs[i], DMBA_REG_RESET);
        wr(DMBA_ADDR_PTR_ONE, 8'hFF);
        rd(DMBA_ADDR_PTR_ONE, 8'hFF);
        wr(DMBA_ADDR_PTR_ZERO, 8'h85);
        wr(8'h85, 8'h3C);
        rd(DMBA_ADDR_IND_ZERO, 8'h3C);
        wr(DMBA_ADDR_BANK, 8'hFF);
        rd(DMBA_ADDR_BANK, 8'h01);
        wr(8'h86, 8'h11);
        wr(DMBA_ADDR_PTR_ONE, 8'h86);
        wr(DMBA_ADDR_IND_ONE, 8'h77);
        rd(8'h86, 8'h11);
        rd(DMBA_ADDR_IND_ONE, 8'h77);
        chk("ram_bank1", 8'h77, u_dmba_mem_model.ram[9'h186]);
        wr(DMBA_ADDR_PTR_ZERO, 8'h86);
        rd(DMBA_ADDR_IND_ZERO, 8'h11);
        wr(DMBA_ADDR_PTR_ZERO, DMBA_ADDR_IND_ONE);
        wr(DMBA_ADDR_IND_ZERO, 8'h55);
        rd(DMBA_ADDR_IND_ZERO, 8'h00);
        rd(DMBA_ADDR_IND_ONE, 8'h77);
        wr(8'h30, 8'hA5);
        wr(DMBA_ADDR_EEPROM_CT, 8'h5A);
        rd(DMBA_ADDR_EEPROM_CT, 8'h5A);
        wr(DMBA_ADDR_BANK, 8'h00);
        rd(8'h30, 8'hA5);
        rd(DMBA_ADDR_EEPROM_CT, 8'h00);
        rd(8'h1C, 8'h00);
        rd(8'h50, 8'h00);
        wr(8'h22, 8'h3F);
        rd(8'h22, 8'h00);
        @(negedge clock_i);
        alu_we_i     = 1'b1;
        alu_result_i = 8'hC3;
        @(negedge clock_i);
        alu_we_i     = 1'b0;
        chk("acc", 8'hC3, acc_o);
        rd(DMBA_ADDR_ACC, 8'hC3);
        rd(DMBA_ADDR_PCL, 8'h9A);
        wr(DMBA_ADDR_PCL, 8'h42);
        chk("jump", 8'h01, {7'h00, pc_jump_o});
        chk("jump_low", 8'h42, pc_jump_low_o);
        chk("dummy", 8'h01, {7'h00, pc_dummy_o});
        chk("ready", 8'h00, {7'h00, core_ready_o});
        @(negedge clock_i);
        chk("ready", 8'h01, {7'h00, core_ready_o});
        wr(DMBA_ADDR_TBL_LOW, 8'h34);
        wr(DMBA_ADDR_TBL_HIGH, 8'h12);
        tbl(8'h88);
        rd(8'h88, 8'h6E);
        rd(DMBA_ADDR_TBL_HRES, 8'hB7);
        wr(DMBA_ADDR_TBL_LOW, 8'h33);
        tbl(DMBA_ADDR_ACC);
        chk("acc", 8'h69, acc_o);
        tbl(DMBA_ADDR_PCL);
        chk("jump_low", 8'h69, pc_jump_low_o);
        wr(DMBA_ADDR_BANK, 8'h01);
        do_reset(1'b1);
        rd(DMBA_ADDR_BANK, 8'h01);
        do_reset(1'b0);
        rd(DMBA_ADDR_BANK, 8'h00);
        close_out();
    end
endmodule
